// File: core/tickle_pkg.sv
package tickle_pkg;

  // Clock and times in their own units
  localparam int CLK_PERIOD_NS  = 20;
  localparam int WINDOW_NS      = 200000;
  localparam int TICKLE_RATE_HZ = 5000;
  localparam int TICKLE_LEN_NS  = 4000;
  localparam int PRESET_NS      = 4000;
  localparam int MAX_PULSE_NS   = 1000000;

  // Derived cycle counts
  localparam int WINDOW_CYC   = WINDOW_NS / CLK_PERIOD_NS;
  localparam int RATE_CYC     = 1000000000 / TICKLE_RATE_HZ / CLK_PERIOD_NS;
  localparam int TICKLE_CYC   = TICKLE_LEN_NS / CLK_PERIOD_NS;
  localparam int PRESET_CYC   = PRESET_NS / CLK_PERIOD_NS;
  localparam int MAX_HIGH_CYC = MAX_PULSE_NS / CLK_PERIOD_NS;

  // Counter and pointer widths
  localparam int CNT_W  = 16;
  localparam int ADDR_W = 14;

endpackage

// File: core/cmd_history_mem.sv
`timescale 1ns/1ns
module cmd_history_mem #(
  parameter int DEPTH  = 10000,
  parameter int ADDR_W = 14
) (
  // Clock
  input  wire logic              clk_sys_i,
  // Access port, read before write at one address
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic              wdata_i,
  output logic                   rdata_o
);

  logic mem_q [DEPTH];

  // Old sample out, new sample in
  always_ff @(posedge clk_sys_i)
  begin
    rdata_o      <= mem_q[addr_i];
    mem_q[addr_i] <= wdata_i;
  end

endmodule

// File: core/pwm_tickle_gen.sv
`timescale 1ns/1ns
module pwm_tickle_gen
  import tickle_pkg::*;
#(
  parameter int WIN_CYC  = tickle_pkg::WINDOW_CYC,
  parameter int TICK_CYC = tickle_pkg::RATE_CYC,
  parameter int MAXH_CYC = tickle_pkg::MAX_HIGH_CYC
) (
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic nrst_i,
  // Command from the external source
  input  wire logic pwm_cmd_i,
  // Drive and status
  output logic      rf_en_o,
  output logic      fault_o,
  output logic      tickle_o
);

  import tickle_pkg::*;

  logic [CNT_W-1:0]  win_last;
  logic [CNT_W-1:0]  tick_last;
  logic [CNT_W-1:0]  maxh_last;
  logic [CNT_W-1:0]  preset_v;
  logic [CNT_W-1:0]  tkl_last;
  assign win_last  = CNT_W'(WIN_CYC - 1);
  assign tick_last = CNT_W'(TICK_CYC - 1);
  assign maxh_last = CNT_W'(MAXH_CYC - 1);
  assign preset_v  = CNT_W'(PRESET_CYC);
  assign tkl_last  = CNT_W'(TICKLE_CYC - 1);

  logic              sync1_q;
  logic              cmd_s;
  logic              new_q;
  logic              old_vld_q;
  logic              old_bit;
  logic              filled_q;
  logic [ADDR_W-1:0] ptr_q;
  logic [CNT_W-1:0]  acc_q;
  logic [CNT_W-1:0]  div_q;
  logic              tick_q;
  logic [CNT_W-1:0]  low_cnt_q;
  logic              low_long_q;
  logic [CNT_W-1:0]  high_cnt_q;
  logic              fault_q;
  logic [CNT_W-1:0]  tk_cnt_q;
  logic              tickle_q;

  // Two-stage input synchroniser
  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      sync1_q <= 1'b0;
      cmd_s   <= 1'b0;
    end
    else
    begin
      sync1_q <= pwm_cmd_i;
      cmd_s   <= sync1_q;
    end
  end

  // Ring pointer over the window history
  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      ptr_q    <= '0;
      filled_q <= 1'b0;
    end
    else if (CNT_W'(ptr_q) == win_last)
    begin
      ptr_q    <= '0;
      filled_q <= 1'b1;
    end
    else
      ptr_q <= ptr_q + 1'b1;
  end

  cmd_history_mem #(
    .DEPTH  (WINDOW_CYC),
    .ADDR_W (ADDR_W)
  ) u_hist (
    .clk_sys_i (clk_sys_i),
    .addr_i    (ptr_q),
    .wdata_i   (cmd_s),
    .rdata_o   (old_bit)
  );

  // Sliding sum: add newest sample, drop the one leaving
  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      new_q     <= 1'b0;
      old_vld_q <= 1'b0;
      acc_q     <= '0;
    end
    else
    begin
      new_q     <= cmd_s;
      old_vld_q <= filled_q;
      acc_q     <= acc_q + CNT_W'(new_q) - CNT_W'(old_vld_q & old_bit);
    end
  end

  // 5 kHz enable divider
  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      tick_q <= (div_q == tick_last);
      div_q  <= (div_q == tick_last) ? '0 : div_q + 1'b1;
    end
  end

  // Command low time; long only after a full window low
  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      low_cnt_q  <= '0;
      low_long_q <= 1'b0;
    end
    else if (cmd_s)
    begin
      low_cnt_q  <= '0;
      low_long_q <= 1'b0;
    end
    else if (low_cnt_q <= win_last)
      low_cnt_q <= low_cnt_q + 1'b1;
    else
      low_long_q <= 1'b1;
  end

  // Stuck-high detect, cleared as soon as command drops
  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      high_cnt_q <= '0;
      fault_q    <= 1'b0;
    end
    else if (!cmd_s)
    begin
      high_cnt_q <= '0;
      fault_q    <= 1'b0;
    end
    else if (high_cnt_q == maxh_last)
      fault_q <= 1'b1;
    else
      high_cnt_q <= high_cnt_q + 1'b1;
  end

  // Keep-alive pulse: on tick, idle long enough, window short
  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      tickle_q <= 1'b0;
      tk_cnt_q <= '0;
    end
    else if (tickle_q)
    begin
      tk_cnt_q <= tk_cnt_q + 1'b1;
      if (tk_cnt_q == tkl_last)
        tickle_q <= 1'b0;
    end
    else if (tick_q && low_long_q && !(acc_q > preset_v))
    begin
      tickle_q <= 1'b1;
      tk_cnt_q <= '0;
    end
  end

  // Drive is command unless faulted, or keep-alive, merged
  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      rf_en_o  <= 1'b0;
      fault_o  <= 1'b0;
      tickle_o <= 1'b0;
    end
    else
    begin
      rf_en_o  <= (cmd_s & ~fault_q) | tickle_q;
      fault_o  <= fault_q;
      tickle_o <= tickle_q;
    end
  end

  // Checks
  localparam int A_TK = TICKLE_CYC - 1;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!nrst_i);

  a_rf_follows_cmd: assert property (cmd_s && !fault_q |=> rf_en_o)
    else $error("drive missing while commanded");
  a_rf_off_low: assert property (!cmd_s && !tickle_q |=> !rf_en_o)
    else $error("drive on while command low");
  a_tickle_width: assert property ($rose(tickle_q) |-> ##A_TK tickle_q ##1 !tickle_q)
    else $error("keep-alive width wrong");
  a_tickle_on_tick: assert property ($rose(tickle_q) |-> $past(tick_q))
    else $error("keep-alive off rate tick");
  a_tickle_suppress: assert property ($rose(tickle_q) |-> $past(acc_q) <= preset_v)
    else $error("keep-alive despite enough on time");
  a_tickle_idle: assert property ($rose(tickle_q) |-> $past(low_long_q))
    else $error("keep-alive without long idle");
  a_tickle_emit: assert property (tick_q && low_long_q && !tickle_q
    && acc_q <= preset_v |=> tickle_q ##1 tickle_o)
    else $error("keep-alive not emitted");
  a_fault_release: assert property (fault_q && !cmd_s |=> !fault_q ##1 !fault_o)
    else $error("fault not released");
  a_acc_bound: assert property (acc_q <= CNT_W'(WIN_CYC))
    else $error("window sum out of range");

  c_tickle: cover property ($rose(tickle_q));
  c_fault: cover property ($rose(fault_o));
  c_merge: cover property (tickle_q && cmd_s);

endmodule

// File: verif/pwm_cmd_src.sv
`timescale 1ns/1ns
module pwm_cmd_src (
  // Clock
  input  wire logic        clk_sys_i,
  // Pulse request
  input  wire logic        go_i,
  input  wire logic [15:0] hi_len_i,
  input  wire logic [15:0] lo_len_i,
  // Command line and status
  output logic             cmd_o,
  output logic             busy_o
);
  // One high then low pulse per request, no keep-alive of its own
  initial
  begin
    cmd_o  = 1'b0;
    busy_o = 1'b0;
    forever
    begin
      do @(posedge clk_sys_i); while (go_i !== 1'b1);
      @(negedge clk_sys_i);
      busy_o = 1'b1;
      cmd_o  = 1'b1;
      repeat (hi_len_i) @(negedge clk_sys_i);
      cmd_o = 1'b0;
      repeat (lo_len_i) @(negedge clk_sys_i);
      busy_o = 1'b0;
    end
  end
endmodule

// File: verif/pwm_tickle_gen_tb.sv
`timescale 1ns/1ns
module pwm_tickle_gen_tb;
  import tickle_pkg::*;
  localparam int TICK = 400;
  localparam int MAXH = 1000;
  logic        clk_sys_i;
  logic        nrst_i;
  logic        go;
  logic [15:0] hi_len;
  logic [15:0] lo_len;
  logic        pwm_cmd;
  logic        busy;
  logic        rf_en_o;
  logic        fault_o;
  logic        tickle_o;
  int          n_fail, checked, cyc, run, t0, h, seed;
  int          notes[$];

  pwm_tickle_gen #(.WIN_CYC(400), .TICK_CYC(TICK), .MAXH_CYC(MAXH)) u_pwm_tickle_gen (
    .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .pwm_cmd_i(pwm_cmd),
    .rf_en_o(rf_en_o), .fault_o(fault_o), .tickle_o(tickle_o));
  pwm_cmd_src u_pwm_cmd_src (.clk_sys_i(clk_sys_i), .go_i(go), .hi_len_i(hi_len),
    .lo_len_i(lo_len), .cmd_o(pwm_cmd), .busy_o(busy));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %0d seen %0d", nm, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // One command pulse, entered and left at a falling edge
  task automatic pulse(input int hi, input int lo);
    hi_len = hi[15:0];
    lo_len = lo[15:0];
    go     = 1'b1;
    @(negedge clk_sys_i);
    go = 1'b0;
    @(posedge clk_sys_i);
    while (busy) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
  endtask

  task automatic wait_tk(input logic lvl);
    while (tickle_o !== lvl) @(negedge clk_sys_i);
  endtask

  // Clock
  initial
  begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end

  // Cycle count and hang limit
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      end_sim();
    end
  end

  // Each drive run length against the oldest note
  always @(negedge clk_sys_i)
  begin
    if (rf_en_o === 1'b1)
      run++;
    else if (run > 0)
    begin
      if (notes.size() == 0)
        chk("extra drive run", run, 0);
      else
        chk("drive run", run, notes.pop_front());
      run = 0;
    end
  end

  // Stimulus
  initial
  begin
    nrst_i = 1'b0;
    go     = 1'b0;
    hi_len = 16'h0000;
    lo_len = 16'h0000;
    seed   = 32'hDF6C041D;
    repeat (8) @(negedge clk_sys_i);
    chk("rf_en in reset", rf_en_o, 0);
    chk("fault in reset", fault_o, 0);
    chk("tickle in reset", tickle_o, 0);
    nrst_i = 1'b1;
    // Idle line: keep-alive length and rate
    wait_tk(1'b1);
    notes.push_back(TICKLE_CYC);
    t0 = cyc;
    wait_tk(1'b0);
    wait_tk(1'b1);
    notes.push_back(TICKLE_CYC);
    chk("keep-alive period", cyc - t0, TICK);
    wait_tk(1'b0);
    $display("idle done");
    // Random dense burst, no keep-alive expected
    for (int i = 0; i < 8; i++)
    begin
      h = 60 + {$random(seed)} % 40;
      notes.push_back(h);
      pulse(h, 20 + {$random(seed)} % 40);
    end
    // Low gaps just short of the window
    repeat (3)
    begin
      notes.push_back(10);
      pulse(10, 395);
      chk("no keep-alive", tickle_o, 0);
    end
    $display("burst done");
    // Command merging into a keep-alive
    wait_tk(1'b1);
    notes.push_back(50 + 300 + 3);
    repeat (49) @(negedge clk_sys_i);
    pulse(300, 20);
    $display("merge done");
    // Stuck high command, then resume
    notes.push_back(MAXH);
    hi_len = 16'h044C;
    lo_len = 16'h000A;
    go     = 1'b1;
    @(negedge clk_sys_i);
    go = 1'b0;
    repeat (1060) @(negedge clk_sys_i);
    chk("fault set", fault_o, 1);
    chk("drive off", rf_en_o, 0);
    @(posedge clk_sys_i);
    while (busy) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    chk("fault clear", fault_o, 0);
    notes.push_back(50);
    pulse(50, 20);
    $display("fault done");
    chk("notes left", notes.size(), 0);
    end_sim();
  end
endmodule
